// [bsis_checker_assertions.sv]
// port assertions for the boot select and serial sync controller
`timescale 1ns/100ps
module bsis_checker
#(
	parameter [17:0] SAMPLE_CYCLES = 18'd20,
	parameter [22:0] ERASE_CYCLES = 23'd100,
	parameter [15:0] PROG_CYCLES = 16'd20,
	parameter [6:0] FLASH_KB = 7'd32
)
(
	input wire i_clock,
	input wire i_nrst,
	input wire i_can_present,
	input wire i_interface_select_pin,
	input wire o_flash_rd,
	input wire o_vec_remap,
	input wire [31:0] o_fetch_base,
	input wire o_run_user,
	input wire o_can_handler,
	input wire o_isp_active,
	input wire i_cmd_valid,
	input wire [2:0] i_cmd_code,
	input wire o_cmd_ready,
	input wire o_cmd_refused,
	input wire o_go,
	input wire o_unlocked,
	input wire o_flash_erase,
	input wire o_flash_prog,
	input wire [3:0] o_sector
);
	reg [23:0] since_rst;
	reg [23:0] busy_len;
	// cycles since reset release and length of the current busy spell
	always @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			since_rst <= 24'h0;
			busy_len <= 24'h0;
		end
		else
		begin
			since_rst <= (since_rst == 24'hffffff) ? since_rst : since_rst + 24'h1;
			busy_len <= (o_flash_erase | o_flash_prog) ? busy_len + 24'h1 : 24'h0;
		end
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	sample_delay_a: assert property (o_flash_rd |-> since_rst <= SAMPLE_CYCLES + 24'd12)
		else $error("boot reads start too late");
	erase_time_a: assert property ($fell(o_flash_erase) |-> busy_len * 100 >= ERASE_CYCLES * 95
		&& busy_len * 100 <= ERASE_CYCLES * 105) else $error("erase time off");
	prog_time_a: assert property ($fell(o_flash_prog) |-> busy_len * 100 >= PROG_CYCLES * 95
		&& busy_len * 100 <= PROG_CYCLES * 105) else $error("program time off");
	locked_refuse_a: assert property (i_cmd_valid && o_cmd_ready && !o_unlocked
		&& i_cmd_code inside {3'h2, 3'h3, 3'h4} |-> ##[1:2] o_cmd_refused) else $error("locked command taken");
	unlock_gate_a: assert property ((o_flash_erase | o_flash_prog | o_go) |-> o_unlocked)
		else $error("flash action while locked");
	sector_range_a: assert property ((o_flash_erase | o_flash_prog) |-> o_sector < (FLASH_KB >> 2))
		else $error("sector beyond flash size");
	user_map_a: assert property (o_run_user |-> !o_vec_remap && o_fetch_base == 32'h0 && !o_isp_active)
		else $error("user code with boot map");
	can_pick_a: assert property ($rose(o_can_handler) |-> o_isp_active && i_can_present
		&& !i_interface_select_pin) else $error("wrong handler chosen");
endmodule
bind bsis_top bsis_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES),
	.PROG_CYCLES(PROG_CYCLES), .FLASH_KB(FLASH_KB)) u_check (.i_clock(i_clock), .i_nrst(i_nrst),
	.i_can_present(i_can_present), .i_interface_select_pin(i_interface_select_pin), .o_flash_rd(o_flash_rd),
	.o_vec_remap(o_vec_remap), .o_fetch_base(o_fetch_base), .o_run_user(o_run_user),
	.o_can_handler(o_can_handler), .o_isp_active(o_isp_active), .i_cmd_valid(i_cmd_valid),
	.i_cmd_code(i_cmd_code), .o_cmd_ready(o_cmd_ready), .o_cmd_refused(o_cmd_refused), .o_go(o_go),
	.o_unlocked(o_unlocked), .o_flash_erase(o_flash_erase), .o_flash_prog(o_flash_prog), .o_sector(o_sector));

// [bsis_host.sv]
// serial programming host model on the 8N1 line
`timescale 1ns/100ps
module bsis_host
(
	input wire i_clock,
	input wire i_txd,
	output reg o_rxd
);
	// line idles high between characters
	initial o_rxd = 1'b1;
	// one character, lsb first, 8 data bits, 1 stop bit, no parity
	task send_byte(input int div, input [7:0] b);
		int i;
		for (i = 0; i < 10; i++)
		begin
			@(negedge i_clock);
			o_rxd = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (div - 1) @(negedge i_clock);
		end
	endtask
	// sends a whole string back to back
	task send_str(input int div, input string s);
		int i;
		for (i = 0; i < s.len(); i++)
			send_byte(div, s[i]);
	endtask
	// waits for a start bit, then samples each bit mid-way
	task get_byte(input int div, output logic [7:0] b);
		int n;
		int i;
		n = 0;
		b = 8'hxx;
		while (i_txd !== 1'b0 && n < 5000)
		begin
			@(posedge i_clock);
			n++;
		end
		if (n < 5000)
		begin
			repeat (div / 2) @(posedge i_clock);
			for (i = 0; i < 8; i++)
			begin
				repeat (div) @(posedge i_clock);
				b[i] = i_txd;
			end
			repeat (div) @(posedge i_clock);
		end
	endtask
endmodule

// [bsis_map.vh]
// constants for the boot select and serial sync controller
`ifndef BSIS_MAP_VH
`define BSIS_MAP_VH
`define BSIS_CLK_MHZ 50
`define BSIS_ERASE_US 100000
`define BSIS_ERASE_CYC (`BSIS_ERASE_US * `BSIS_CLK_MHZ)
`define BSIS_PROG_US 1000
`define BSIS_PROG_CYC (`BSIS_PROG_US * `BSIS_CLK_MHZ)
`define BSIS_PROG_BYTES 256
`define BSIS_SAMPLE_US 3000
`define BSIS_SAMPLE_CYC (`BSIS_SAMPLE_US * `BSIS_CLK_MHZ)
`define BSIS_BOOT_BASE 32'h1fff_0000
`define BSIS_BOOT_KB 16
`define BSIS_VEC_BYTES 512
`define BSIS_USER_BASE 32'h0000_0000
`define BSIS_RAM_KEEP_LO 32'h1000_0000
`define BSIS_RAM_KEEP_HI 32'h1000_0050
`define BSIS_SKIP_ADDR 32'h0000_02fc
`define BSIS_SKIP_VALUE 32'ha5a5_5a5a
`define BSIS_CKSUM_WORDS 4'h8
`define BSIS_SECTOR_KB 4
`define BSIS_SECTOR_SHIFT 12
`define BSIS_SYNC_CHAR 8'h3f
`define BSIS_CR 8'h0d
`define BSIS_LF 8'h0a
`define BSIS_DIV_MIN 16'h0004
`define BSIS_DIV_MAX 16'h0fff
`define BSIS_SYNC_LAST 4'hd
`define BSIS_OK_LAST 4'h3
`define BSIS_CMD_UNLOCK 3'h1
`define BSIS_CMD_ERASE 3'h2
`define BSIS_CMD_WRITE 3'h3
`define BSIS_CMD_GO 3'h4
`endif

// [bsis_top.v]
// boot selection, user code check, serial autobaud sync and flash command gate
// How it works
// R1 - a sector erase holds the flash busy for 100 ms
// R2 - programming one 256-byte block holds the flash busy for 1 ms
// R3 - the boot sequence runs after every reset before user code
// R4 - boot request pin low after reset asks for the programming handler
// R5 - boot logic never touches RAM 0x1000_0000 to 0x1000_0050
// R6 - with CAN present, interface select low picks CAN, high picks serial
// R7 - the boot request pin is sampled within 3 ms after reset release
// R8 - a set watchdog overflow flag vetoes the pin request
// R9 - no request: valid user code runs, else autobaud starts
// R10 - a designated word at flash 0x2fc suppresses pin sampling
// R11 - boot code runs from a 16 kB block at 0x1fff_0000
// R12 - after reset the low 512 boot bytes appear at address zero
// R13 - user code valid only when the first 8 flash words sum to zero
// R14 - the host sends question mark 0x3f and waits for the reply
// R15 - the host uses 8 data bits, 1 stop bit, no parity
// R16 - the sync bit time is measured, sets the divisor, Synchronized CR LF sent
// R17 - the host echoes the sync string with CR LF
// R18 - a good echo answers OK CR LF, a bad one restarts sync
// R19 - the host sends clock kHz in decimal, the device answers OK CR LF
// R20 - after the frequency text the command handler is entered
// R21 - autobaud is only guaranteed with a core clock of 10 MHz or more
// R22 - erase, write and go are refused until unlock is accepted
// R23 - sectors are 4 kB, sector n starts at n times 0x1000
// R24 - implemented sectors follow flash size, 2 to 8 sectors
// R25 - sync timing runs start edge to next rise, bad divisors dropped
`timescale 1ns/100ps
`include "bsis_map.vh"
module bsis_top
#(
	parameter [17:0] SAMPLE_CYCLES = `BSIS_SAMPLE_CYC,
	parameter [22:0] ERASE_CYCLES = `BSIS_ERASE_CYC,
	parameter [15:0] PROG_CYCLES = `BSIS_PROG_CYC,
	parameter [6:0] FLASH_KB = 7'd32
)
(
	input wire i_clock,
	input wire i_nrst,
	input wire i_boot_request_pin,
	input wire i_interface_select_pin,
	input wire i_can_present,
	input wire i_wdt_overflow,
	output reg o_flash_rd,
	output reg [31:0] o_flash_addr,
	input wire [31:0] i_flash_rdata,
	input wire i_rxd,
	output wire o_txd,
	output reg o_vec_remap,
	output reg [31:0] o_fetch_base,
	output reg o_run_user,
	output reg o_can_handler,
	output reg o_isp_active,
	output reg [11:0] o_baud_div,
	output reg [19:0] o_freq_khz,
	input wire i_cmd_valid,
	input wire [2:0] i_cmd_code,
	input wire [3:0] i_cmd_sector,
	output wire o_cmd_ready,
	output reg o_cmd_done,
	output reg o_cmd_refused,
	output reg o_go,
	output reg o_unlocked,
	output reg o_flash_erase,
	output reg o_flash_prog,
	output reg [3:0] o_sector
);
	localparam [14:0] ST_DELAY = 15'h0001;
	localparam [14:0] ST_SKIPRD = 15'h0002;
	localparam [14:0] ST_SAMPLE = 15'h0004;
	localparam [14:0] ST_CHECK = 15'h0008;
	localparam [14:0] ST_USER = 15'h0010;
	localparam [14:0] ST_CAN = 15'h0020;
	localparam [14:0] ST_BWAIT = 15'h0040;
	localparam [14:0] ST_BMEAS = 15'h0080;
	localparam [14:0] ST_TXSYNC = 15'h0100;
	localparam [14:0] ST_RXECHO = 15'h0200;
	localparam [14:0] ST_TXOK1 = 15'h0400;
	localparam [14:0] ST_RXFREQ = 15'h0800;
	localparam [14:0] ST_TXOK2 = 15'h1000;
	localparam [14:0] ST_CMD = 15'h2000;
	localparam [14:0] ST_SPARE = 15'h4000;

	reg [14:0] state;
	reg [17:0] dcnt;
	reg skip_sample;
	reg [3:0] widx;
	reg [31:0] sum;
	reg [15:0] meas;
	reg rx_prev;
	reg [3:0] txi;
	reg [3:0] rxi;
	reg mism;
	reg [22:0] busy_cnt;
	wire tx_ready;
	wire rx_valid;
	wire [7:0] rx_data;
	wire tx_state;
	wire tx_last;
	wire [7:0] tx_char;
	wire [3:0] digit;
	wire [19:0] freq_next;

	// characters of the two reply strings, Synchronized CR LF and OK CR LF
	function [7:0] bsis_text;
		input ok;
		input [3:0] idx;
		begin
			case ({ok, idx})
				5'h00: bsis_text = 8'h53;
				5'h01: bsis_text = 8'h79;
				5'h02: bsis_text = 8'h6e;
				5'h03: bsis_text = 8'h63;
				5'h04: bsis_text = 8'h68;
				5'h05: bsis_text = 8'h72;
				5'h06: bsis_text = 8'h6f;
				5'h07: bsis_text = 8'h6e;
				5'h08: bsis_text = 8'h69;
				5'h09: bsis_text = 8'h7a;
				5'h0a: bsis_text = 8'h65;
				5'h0b: bsis_text = 8'h64;
				5'h0c: bsis_text = `BSIS_CR;
				5'h0d: bsis_text = `BSIS_LF;
				5'h10: bsis_text = 8'h4f;
				5'h11: bsis_text = 8'h4b;
				5'h12: bsis_text = `BSIS_CR;
				5'h13: bsis_text = `BSIS_LF;
				default: bsis_text = 8'h00;
			endcase
		end
	endfunction

	// sector exists for the configured flash size
	function sector_ok;
		input [3:0] n;
		begin
			sector_ok = ({3'h0, n} < (FLASH_KB / `BSIS_SECTOR_KB)); // see R24
		end
	endfunction

	// serial side of the sync exchange
	assign tx_state = (state == ST_TXSYNC) || (state == ST_TXOK1) || (state == ST_TXOK2);
	assign tx_char = bsis_text(state != ST_TXSYNC, txi); // see R16 see R18 see R19
	assign tx_last = (state == ST_TXSYNC) ? (txi == `BSIS_SYNC_LAST) : (txi == `BSIS_OK_LAST);
	assign o_cmd_ready = (state == ST_CMD) && !o_flash_erase && !o_flash_prog;
	assign digit = rx_data[3:0];
	assign freq_next = o_freq_khz * 20'd10 + {16'h0000, digit};

	bsis_uart u_uart
	(
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_div(o_baud_div),
		.i_rxd(i_rxd),
		.i_rx_en((state == ST_RXECHO) || (state == ST_RXFREQ)),
		.o_rx_valid(rx_valid),
		.o_rx_data(rx_data),
		.i_tx_valid(tx_state),
		.i_tx_data(tx_char),
		.o_tx_ready(tx_ready),
		.o_txd(o_txd)
	);

	// boot sequencer; only flash is read, no RAM port exists at all
	always @(posedge i_clock or negedge i_nrst) // see R3 see R5
	begin
		if (!i_nrst)
		begin
			state <= ST_DELAY;
			dcnt <= 18'h00000;
			skip_sample <= 1'b0;
			widx <= 4'h0;
			sum <= 32'h0000_0000;
			meas <= 16'h0000;
			rx_prev <= 1'b1;
			txi <= 4'h0;
			rxi <= 4'h0;
			mism <= 1'b0;
			o_flash_rd <= 1'b0;
			o_flash_addr <= 32'h0000_0000;
			o_vec_remap <= 1'b1; // see R12
			o_fetch_base <= `BSIS_BOOT_BASE; // see R11
			o_run_user <= 1'b0;
			o_can_handler <= 1'b0;
			o_isp_active <= 1'b0;
			o_baud_div <= 12'hfff;
			o_freq_khz <= 20'h00000;
		end
		else
		begin
			o_flash_rd <= 1'b0;
			rx_prev <= i_rxd;
			case (state)
				// wait the startup time before looking at the pins
				ST_DELAY:
				begin
					dcnt <= dcnt + 18'h00001;
					if (dcnt == SAMPLE_CYCLES - 18'h00001) // see R7
					begin
						state <= ST_SKIPRD;
						o_flash_rd <= 1'b1;
						o_flash_addr <= `BSIS_SKIP_ADDR;
					end
				end
				// read word that may disable the request pin
				ST_SKIPRD:
				begin
					skip_sample <= (i_flash_rdata == `BSIS_SKIP_VALUE); // see R10
					state <= ST_SAMPLE;
				end
				ST_SAMPLE:
				begin
					widx <= 4'h0;
					sum <= 32'h0000_0000;
					if (!skip_sample && !i_boot_request_pin && !i_wdt_overflow) // see R4 see R8
					begin
						if (i_can_present && !i_interface_select_pin) // see R6
						begin
							state <= ST_CAN;
							o_can_handler <= 1'b1;
							o_isp_active <= 1'b1;
						end
						else
							state <= ST_BWAIT;
					end
					else
						state <= ST_CHECK; // see R9
				end
				// sum the first eight words of sector 0
				ST_CHECK:
				begin
					if (o_flash_rd)
						sum <= sum + i_flash_rdata; // see R13
					if (widx != `BSIS_CKSUM_WORDS)
					begin
						o_flash_rd <= 1'b1;
						o_flash_addr <= {26'h0000000, widx, 2'b00};
						widx <= widx + 4'h1;
					end
					else if (!o_flash_rd)
					begin
						if (sum == 32'h0000_0000) // see R9 see R13
						begin
							state <= ST_USER;
							o_run_user <= 1'b1;
							o_vec_remap <= 1'b0;
							o_fetch_base <= `BSIS_USER_BASE;
						end
						else
							state <= ST_BWAIT;
					end
				end
				ST_USER:
					state <= ST_USER;
				ST_CAN:
					state <= ST_CAN;
				// wait for the start edge of the sync character
				ST_BWAIT:
				begin
					if (rx_prev && !i_rxd) // see R25
					begin
						meas <= 16'h0001;
						state <= ST_BMEAS;
					end
				end
				// first rise after start is one bit time for 0x3f
				ST_BMEAS:
				begin
					meas <= meas + 16'h0001;
					if (!rx_prev && i_rxd) // see R16 see R25
					begin
						if (meas >= `BSIS_DIV_MIN && meas <= `BSIS_DIV_MAX) // see R21 see R25
						begin
							o_baud_div <= meas[11:0];
							txi <= 4'h0;
							state <= ST_TXSYNC;
						end
						else
							state <= ST_BWAIT;
					end
					else if (meas == 16'hffff)
						state <= ST_BWAIT; // too slow, drop
				end
				ST_TXSYNC:
				begin
					if (tx_ready)
					begin
						txi <= tx_last ? 4'h0 : txi + 4'h1;
						if (tx_last)
						begin
							rxi <= 4'h0;
							mism <= 1'b0;
							state <= ST_RXECHO;
						end
					end
				end
				// compare the echoed string
				ST_RXECHO:
				begin
					if (rx_valid)
					begin
						rxi <= rxi + 4'h1;
						mism <= mism | (rx_data != bsis_text(1'b0, rxi));
						if (rxi == `BSIS_SYNC_LAST)
						begin
							if (mism || rx_data != bsis_text(1'b0, rxi)) // see R18
								state <= ST_BWAIT;
							else
								state <= ST_TXOK1;
						end
					end
				end
				ST_TXOK1:
				begin
					if (tx_ready)
					begin
						txi <= tx_last ? 4'h0 : txi + 4'h1;
						if (tx_last)
						begin
							o_freq_khz <= 20'h00000;
							state <= ST_RXFREQ;
						end
					end
				end
				// decimal kHz text, ends at line feed
				ST_RXFREQ:
				begin
					if (rx_valid)
					begin
						if (rx_data == `BSIS_LF)
							state <= ST_TXOK2; // see R19
						else if (rx_data >= 8'h30 && rx_data <= 8'h39)
							o_freq_khz <= freq_next;
					end
				end
				ST_TXOK2:
				begin
					if (tx_ready)
					begin
						txi <= tx_last ? 4'h0 : txi + 4'h1;
						if (tx_last)
						begin
							state <= ST_CMD; // see R20
							o_isp_active <= 1'b1;
						end
					end
				end
				ST_CMD:
					state <= ST_CMD;
				default:
					state <= ST_DELAY;
			endcase
		end
	end

	// command gate and flash operation timing
	always @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			busy_cnt <= 23'h000000;
			o_cmd_done <= 1'b0;
			o_cmd_refused <= 1'b0;
			o_go <= 1'b0;
			o_unlocked <= 1'b0;
			o_flash_erase <= 1'b0;
			o_flash_prog <= 1'b0;
			o_sector <= 4'h0;
		end
		else
		begin
			o_cmd_done <= 1'b0;
			o_cmd_refused <= 1'b0;
			o_go <= 1'b0;
			if (o_flash_erase || o_flash_prog)
			begin
				busy_cnt <= busy_cnt - 23'h000001;
				if (busy_cnt == 23'h000001) // see R1 see R2
				begin
					o_flash_erase <= 1'b0;
					o_flash_prog <= 1'b0;
					o_cmd_done <= 1'b1;
				end
			end
			else if (o_cmd_ready && i_cmd_valid)
			begin
				o_sector <= i_cmd_sector; // see R23
				case (i_cmd_code)
					`BSIS_CMD_UNLOCK:
					begin
						o_unlocked <= 1'b1;
						o_cmd_done <= 1'b1;
					end
					`BSIS_CMD_ERASE:
					begin
						if (!o_unlocked || !sector_ok(i_cmd_sector)) // see R22 see R24
							o_cmd_refused <= 1'b1;
						else
						begin
							o_flash_erase <= 1'b1;
							busy_cnt <= ERASE_CYCLES; // see R1
						end
					end
					`BSIS_CMD_WRITE:
					begin
						if (!o_unlocked || !sector_ok(i_cmd_sector)) // see R22
							o_cmd_refused <= 1'b1;
						else
						begin
							o_flash_prog <= 1'b1;
							busy_cnt <= {7'h00, PROG_CYCLES}; // see R2
						end
					end
					`BSIS_CMD_GO:
					begin
						if (!o_unlocked) // see R22
							o_cmd_refused <= 1'b1;
						else
						begin
							o_go <= 1'b1;
							o_cmd_done <= 1'b1;
						end
					end
					default:
						o_cmd_done <= 1'b1;
				endcase
			end
		end
	end
endmodule

// [bsis_uart.v]
// 8N1 serial receiver and transmitter with a programmable bit divisor
`timescale 1ns/100ps
module bsis_uart
(
	input wire i_clock,
	input wire i_nrst,
	input wire [11:0] i_div,
	input wire i_rxd,
	input wire i_rx_en,
	output reg o_rx_valid,
	output reg [7:0] o_rx_data,
	input wire i_tx_valid,
	input wire [7:0] i_tx_data,
	output wire o_tx_ready,
	output reg o_txd
);
	reg [11:0] rx_cnt;
	reg [3:0] rx_bit;
	reg rx_busy;
	reg [11:0] tx_cnt;
	reg [3:0] tx_bit;
	reg [8:0] tx_shift;

	assign o_tx_ready = (tx_bit == 4'h0);

	// receiver: start found, centre checked, then one sample per bit
	always @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			rx_cnt <= 12'h000;
			rx_bit <= 4'h0;
			rx_busy <= 1'b0;
			o_rx_valid <= 1'b0;
			o_rx_data <= 8'h00;
		end
		else
		begin
			o_rx_valid <= 1'b0;
			if (!rx_busy)
			begin
				if (i_rx_en && !i_rxd)
				begin
					rx_busy <= 1'b1;
					rx_bit <= 4'h0;
					rx_cnt <= {1'b0, i_div[11:1]};
				end
			end
			else if (rx_cnt != 12'h000)
				rx_cnt <= rx_cnt - 12'h001;
			else
			begin
				rx_cnt <= i_div - 12'h001;
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit == 4'h0 && i_rxd)
					rx_busy <= 1'b0; // start glitch
				else if (rx_bit == 4'h9)
				begin
					rx_busy <= 1'b0;
					o_rx_valid <= i_rxd; // framing error drops byte
				end
				else if (rx_bit != 4'h0)
					o_rx_data <= {i_rxd, o_rx_data[7:1]};
			end
		end
	end

	// transmitter: start, 8 data lsb first, one stop
	always @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			tx_cnt <= 12'h000;
			tx_bit <= 4'h0;
			tx_shift <= 9'h1ff;
			o_txd <= 1'b1;
		end
		else if (tx_bit == 4'h0)
		begin
			if (i_tx_valid)
			begin
				o_txd <= 1'b0;
				tx_shift <= {1'b1, i_tx_data};
				tx_bit <= 4'ha;
				tx_cnt <= i_div - 12'h001;
			end
		end
		else if (tx_cnt != 12'h000)
			tx_cnt <= tx_cnt - 12'h001;
		else
		begin
			tx_cnt <= i_div - 12'h001;
			tx_bit <= tx_bit - 4'h1;
			o_txd <= (tx_bit == 4'h1) ? 1'b1 : tx_shift[0];
			tx_shift <= {1'b1, tx_shift[8:1]};
		end
	end
endmodule

// [tb_top.sv]
// testbench for the boot select and serial sync controller
`timescale 1ns/100ps
`include "bsis_map.vh"
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin err_total++; $display("MISMATCH %0t %s", $time, msg); end end
module tb_top;
	reg i_clock;
	reg i_nrst;
	reg boot_pin;
	reg sel_pin;
	reg can_on;
	reg wdt_flag;
	reg skip;
	reg good;
	reg [31:0] flash_rdata;
	reg cmd_valid;
	reg [2:0] cmd_code;
	reg [3:0] cmd_sector;
	wire flash_rd, rxd, txd, vec_remap, run_user, can_handler, isp_active;
	wire cmd_ready, cmd_done, cmd_refused, go, unlocked, flash_erase, flash_prog;
	wire [31:0] flash_addr;
	wire [31:0] fetch_base;
	wire [11:0] baud_div;
	wire [19:0] freq_khz;
	wire [3:0] sector;
	int err_total = 0;
	int total_checks = 0;
	bsis_top #(.SAMPLE_CYCLES(18'd20), .ERASE_CYCLES(23'd100), .PROG_CYCLES(16'd20), .FLASH_KB(7'd32)) i_dut (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_boot_request_pin(boot_pin), .i_interface_select_pin(sel_pin),
		.i_can_present(can_on), .i_wdt_overflow(wdt_flag), .o_flash_rd(flash_rd), .o_flash_addr(flash_addr),
		.i_flash_rdata(flash_rdata), .i_rxd(rxd), .o_txd(txd), .o_vec_remap(vec_remap), .o_fetch_base(fetch_base),
		.o_run_user(run_user), .o_can_handler(can_handler), .o_isp_active(isp_active), .o_baud_div(baud_div),
		.o_freq_khz(freq_khz), .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code), .i_cmd_sector(cmd_sector),
		.o_cmd_ready(cmd_ready), .o_cmd_done(cmd_done), .o_cmd_refused(cmd_refused), .o_go(go),
		.o_unlocked(unlocked), .o_flash_erase(flash_erase), .o_flash_prog(flash_prog), .o_sector(sector));
	bsis_host i_host (.i_clock(i_clock), .i_txd(txd), .o_rxd(rxd));
	// vector words; the last one closes the sum to zero unless spoiled
	function [31:0] word(input [31:0] a);
		integer k;
		word = 32'h0;
		if (a == `BSIS_SKIP_ADDR)
			word = skip ? `BSIS_SKIP_VALUE : 32'h0;
		else if (a != 32'h1c)
			word = a * 32'h0101_0101 + 32'h1357_9bdf;
		else
		begin
			for (k = 0; k < 28; k = k + 4)
				word = word - (k * 32'h0101_0101 + 32'h1357_9bdf);
			word = good ? word : word + 32'h1;
		end
	endfunction
	// flash answers on the falling edge while each read strobe is high
	always @(negedge i_clock)
		if (flash_rd)
			flash_rdata <= word(flash_addr);
	// resets the block with the given pins, then checks the boot choice
	task boot(input sk, input ok, input pin, input sel, input can, input wdt, input [2:0] exp);
		skip = sk;
		good = ok;
		@(negedge i_clock);
		i_nrst = 1'b0;
		boot_pin = pin;
		sel_pin = sel;
		can_on = can;
		wdt_flag = wdt;
		repeat (20) @(negedge i_clock);
		i_nrst = 1'b1;
		repeat (5) @(negedge i_clock);
		`CHK(fetch_base, `BSIS_BOOT_BASE, "boot base")
		`CHK(vec_remap, 1'b1, "vector alias")
		repeat (60) @(negedge i_clock);
		`CHK({run_user, can_handler, isp_active}, exp, "boot path")
		if (exp[2])
			`CHK({vec_remap, fetch_base}, 33'h0, "user map")
	endtask
	// host sends one string while the replies are collected
	task xchg(input int div, input string tx, input string rx);
		int i;
		logic [7:0] b;
		fork
			i_host.send_str(div, tx);
			for (i = 0; i < rx.len(); i++)
			begin
				i_host.get_byte(div, b);
				`CHK(b, rx[i], "reply char")
			end
		join
	endtask
	// autobaud on a question mark, then the echo, spoiled or clean
	task sync(input int div, input bad);
		string s;
		s = "Synchronized\r\n";
		xchg(div, "?", s);
		`CHK(baud_div, div[11:0], "divisor")
		if (bad)
			s[3] = 8'h78;
		xchg(div, s, bad ? "" : "OK\r\n");
	endtask
	// one command; kind 0 done, 1 refused, 2 erase, 3 program, 4 go
	task cmd(input [2:0] code, input [3:0] sec, input int kind);
		int n;
		n = 0;
		@(negedge i_clock);
		cmd_valid = 1'b1;
		cmd_code = code;
		cmd_sector = sec;
		while (cmd_ready !== 1'b1 && n < 100)
		begin
			@(negedge i_clock);
			n++;
		end
		@(negedge i_clock);
		cmd_valid = 1'b0;
		n = 0;
		while (!(cmd_done | cmd_refused | flash_erase | flash_prog) && n < 4)
		begin
			@(negedge i_clock);
			n++;
		end
		`CHK({cmd_refused, flash_erase, flash_prog, go}, {kind == 1, kind == 2, kind == 3, kind == 4}, "answer")
		if (kind == 0)
			`CHK(cmd_done, 1'b1, "done")
		if (kind == 2 || kind == 3)
		begin
			`CHK(sector, sec, "sector")
			n = 0;
			while ((flash_erase | flash_prog) && n < 500)
			begin
				@(negedge i_clock);
				n++;
			end
			// busy span within five percent of the set count
			`CHK(n * 100 >= (kind == 2 ? 9500 : 1900) && n * 100 <= (kind == 2 ? 10500 : 2100), 1'b1, "busy")
			`CHK(cmd_done, 1'b1, "busy done")
		end
	endtask
	// verdict and end of run
	task results;
		if (err_total == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// free-running 50 MHz clock
	initial
	begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end
	// hang guard well beyond the expected run
	initial
	begin
		repeat (60000) @(posedge i_clock);
		err_total++;
		results;
	end
	// boot cases, sync exchange, then the command gate
	initial
	begin
		i_nrst = 1'b0;
		{boot_pin, sel_pin, can_on, wdt_flag, skip, good, cmd_valid} = 7'h7e;
		flash_rdata = 32'h0;
		cmd_code = 3'h0;
		cmd_sector = 4'h0;
		boot(0, 1, 1, 1, 0, 0, 3'b100);
		boot(0, 0, 1, 1, 0, 0, 3'b000);
		boot(0, 1, 0, 0, 1, 0, 3'b011);
		boot(0, 1, 0, 0, 0, 0, 3'b000);
		boot(0, 1, 0, 0, 1, 1, 3'b100);
		boot(1, 1, 0, 0, 1, 0, 3'b100);
		boot(0, 1, 0, 1, 1, 0, 3'b000);
		sync(16, 1);
		sync(20, 0);
		xchg(20, "12\r\n", "OK\r\n");
		`CHK(freq_khz, 20'd12, "frequency")
		`CHK({isp_active, can_handler, unlocked}, 3'b100, "handler")
		cmd(`BSIS_CMD_ERASE, 4'h1, 1);
		cmd(`BSIS_CMD_WRITE, 4'h1, 1);
		cmd(`BSIS_CMD_GO, 4'h0, 1);
		cmd(3'h5, 4'h0, 0);
		cmd(`BSIS_CMD_UNLOCK, 4'h0, 0);
		`CHK(unlocked, 1'b1, "unlocked")
		cmd(`BSIS_CMD_ERASE, 4'h1, 2);
		cmd(`BSIS_CMD_WRITE, 4'h8, 1);
		cmd(`BSIS_CMD_WRITE, 4'h7, 3);
		cmd(`BSIS_CMD_GO, 4'h0, 4);
		results;
	end
endmodule
